//--- core/srrc_pkg.sv
package srrc_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam real EXT_RESET_MIN_US = 10.0;
	localparam int unsigned EXT_RESET_MIN_CYC =
		(int'($ceil(EXT_RESET_MIN_US * real'(CLK_HZ) / 1.0e6)) < 1) ? 1 :
		int'($ceil(EXT_RESET_MIN_US * real'(CLK_HZ) / 1.0e6));
	localparam int unsigned MIN_CNT_W = 8;

	// Stabilization waits in main-clock periods
	localparam int unsigned WAIT_SHORT_CYC = 4096;
	localparam int unsigned WAIT_MID_CYC = 32768;
	localparam int unsigned WAIT_LONG_CYC = 131072;
	localparam int unsigned WAIT_CNT_W = 18;

	// ****************************************
	// Wait select field
	// ****************************************
	localparam logic [2:0] WSEL_RESET = 3'h4;
	localparam logic [2:0] WSEL_SHORT = 3'h0;
	localparam logic [2:0] WSEL_MID = 3'h2;
	localparam logic [2:0] WSEL_LONG = 3'h4;

	localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
	localparam int unsigned NUM_IRQ = 8;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_WSEL = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int unsigned CTRL_HALT_BIT = 0;
	localparam int unsigned CTRL_STOP_BIT = 1;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_RST_WAIT,
		ST_RUN,
		ST_HALT,
		ST_STOP,
		ST_STOP_WAIT
	} srrc_state_t;

	typedef struct packed {
		logic [NUM_IRQ-1:0] request;
		logic [NUM_IRQ-1:0] interrupt_mask_flag;
		logic nmi;
		logic global_interrupt_enable;
	} srrc_irq_t;

	typedef struct packed {
		logic cpu_run;
		logic vector_fetch;
		logic service_irq;
		logic next_instr;
		logic pins_hiz;
		logic osc_enable;
		logic periph_stop;
		logic sub_periph_run;
	} srrc_ctl_t;

endpackage

//--- core/srrc_top.sv
`timescale 1ns/1ps
`default_nettype none
module srrc_top (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic CE_I,
	// Reset sources
	input wire logic RESET_PIN_N_I,
	input wire logic WDT_OVERFLOW_I,
	input wire logic SUPPLY_GOOD_I,
	// Clock status
	input wire logic SUBCLK_RUNNING_I,
	input wire logic SUBCLK_SELECTED_I,
	// Interrupt controller and CPU
	input wire srrc_pkg::srrc_irq_t IRQ_I,
	input wire logic HALT_EXEC_I,
	input wire logic STOP_EXEC_I,
	// Control to the chip
	output srrc_pkg::srrc_ctl_t CTL_O,
	output logic [15:0] VECTOR_ADDR_O,
	output srrc_pkg::srrc_state_t STATE_O,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP
);
	import srrc_pkg::*;

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [WAIT_CNT_W-1:0] wait_len(input logic [2:0] sel);
		unique case (sel)
			WSEL_SHORT: wait_len = WAIT_CNT_W'(WAIT_SHORT_CYC);
			WSEL_MID: wait_len = WAIT_CNT_W'(WAIT_MID_CYC);
			default: wait_len = WAIT_CNT_W'(WAIT_LONG_CYC);
		endcase
	endfunction

	function automatic logic legal_sel(input logic [2:0] sel);
		legal_sel = (sel == WSEL_SHORT) || (sel == WSEL_MID) || (sel == WSEL_LONG);
	endfunction

	// ****************************************
	// Reset merge
	// ****************************************
	logic [MIN_CNT_W-1:0] pin_low_cnt_q;
	logic pin_reset_q;
	logic int_reset;

	// Short glitches on the pin are ignored; only a full minimum low is accepted
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			pin_low_cnt_q <= '0;
			pin_reset_q <= 1'b0;
		end else if (CE_I) begin
			if (RESET_PIN_N_I) begin
				pin_low_cnt_q <= '0;
				pin_reset_q <= 1'b0;
			end else if (pin_low_cnt_q < MIN_CNT_W'(EXT_RESET_MIN_CYC - 1)) begin
				pin_low_cnt_q <= pin_low_cnt_q + MIN_CNT_W'(1);
			end else begin
				pin_reset_q <= 1'b1;
			end
		end
	end

	// One equivalent reset from the three sources
	assign int_reset = pin_reset_q || WDT_OVERFLOW_I || !SUPPLY_GOOD_I;

	// ****************************************
	// Registers
	// ****************************************
	logic [2:0] wsel_q;
	logic sw_halt_q;
	logic sw_stop_q;
	logic addr_ph_q;
	logic write_ph_q;
	logic [7:0] addr_q;
	srrc_state_t state_q;
	logic [1:0] wake_cause_q;

	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			addr_ph_q <= 1'b0;
			write_ph_q <= 1'b0;
			addr_q <= '0;
		end else if (CE_I) begin
			addr_ph_q <= HSEL && HREADY && HTRANS[1];
			write_ph_q <= HSEL && HREADY && HTRANS[1] && HWRITE;
			if (HSEL && HREADY && HTRANS[1]) begin
				addr_q <= HADDR[7:0];
			end
		end
	end

	// Prohibited codes are refused so the wait is always one of three lengths
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I || int_reset) begin
			wsel_q <= WSEL_RESET;
			sw_halt_q <= 1'b0;
			sw_stop_q <= 1'b0;
		end else if (CE_I) begin
			sw_halt_q <= 1'b0;
			sw_stop_q <= 1'b0;
			if (write_ph_q && addr_q == REG_WSEL && legal_sel(HWDATA[2:0])) begin
				wsel_q <= HWDATA[2:0];
			end
			if (write_ph_q && addr_q == REG_CTRL) begin
				sw_halt_q <= HWDATA[CTRL_HALT_BIT];
				sw_stop_q <= HWDATA[CTRL_STOP_BIT];
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			HRDATA <= '0;
		end else if (CE_I) begin
			HRDATA <= '0;
			if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
				unique case (HADDR[7:0])
					REG_WSEL: HRDATA <= {29'h0, wsel_q};
					REG_STATUS: HRDATA <= {27'h0, wake_cause_q, state_q};
					default: HRDATA <= '0;
				endcase
			end
		end
	end

	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	// ****************************************
	// Sequencer
	// ****************************************
	logic wake_any;
	logic wait_start;
	logic wait_done;
	logic [WAIT_CNT_W-1:0] wait_term;
	logic halt_req;
	logic stop_req;

	// Only unmasked requests count, sampled every cycle
	assign wake_any = |(IRQ_I.request & ~IRQ_I.interrupt_mask_flag);
	assign halt_req = HALT_EXEC_I || sw_halt_q;
	assign stop_req = STOP_EXEC_I || sw_stop_q;

	// Reset wait fixed, STOP wait from selector
	assign wait_term = (state_q == ST_STOP || state_q == ST_STOP_WAIT) ?
		wait_len(wsel_q) : WAIT_CNT_W'(WAIT_MID_CYC);
	assign wait_start = ((state_q == ST_RESET) && !int_reset) ||
		((state_q == ST_STOP) && wake_any && !int_reset);

	srrc_wait_counter u_wait (
		.CLK_I(CLK_I),
		.RESET_N_I(RESET_N_I),
		.ce_i(CE_I),
		.start_i(wait_start),
		.terminal_i(wait_term),
		.done_o(wait_done)
	);

	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			state_q <= ST_RESET;
		end else if (CE_I) begin
			if (int_reset) begin
				state_q <= ST_RESET;
			end else begin
				unique case (state_q)
					ST_RESET: state_q <= ST_RST_WAIT;
					ST_RST_WAIT: if (wait_done) state_q <= ST_RUN;
					ST_RUN: begin
						if (stop_req) begin
							state_q <= ST_STOP;
						end else if (halt_req) begin
							state_q <= ST_HALT;
						end
					end
					ST_HALT: if (wake_any || IRQ_I.nmi) state_q <= ST_RUN;
					ST_STOP: if (wake_any) state_q <= ST_STOP_WAIT;
					ST_STOP_WAIT: if (wait_done) state_q <= ST_RUN;
					default: state_q <= ST_RESET;
				endcase
			end
		end
	end

	// 0 none, 1 next instruction, 2 servicing, 3 reset vector
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I || int_reset) begin
			wake_cause_q <= 2'h3;
		end else if (CE_I) begin
			if (state_q == ST_HALT && IRQ_I.nmi) begin
				wake_cause_q <= 2'h2;
			end else if ((state_q == ST_HALT || state_q == ST_STOP) && wake_any) begin
				wake_cause_q <= IRQ_I.global_interrupt_enable ? 2'h2 : 2'h1;
			end
			// Cause holds until the next wake, so software can still read it in RUN
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic entering_run;
	assign entering_run = (state_q != ST_RUN) && !int_reset &&
		(((state_q == ST_RST_WAIT || state_q == ST_STOP_WAIT) && wait_done) ||
		(state_q == ST_HALT && (wake_any || IRQ_I.nmi)));

	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			CTL_O <= '0;
			VECTOR_ADDR_O <= '0;
		end else if (CE_I) begin
			CTL_O.cpu_run <= entering_run || (state_q == ST_RUN && !int_reset &&
				!stop_req && !halt_req);
			CTL_O.vector_fetch <= entering_run && state_q == ST_RST_WAIT;
			CTL_O.service_irq <= entering_run && state_q != ST_RST_WAIT &&
				((state_q == ST_HALT && IRQ_I.nmi) || IRQ_I.global_interrupt_enable);
			CTL_O.next_instr <= entering_run && state_q != ST_RST_WAIT &&
				!(state_q == ST_HALT && IRQ_I.nmi) && !IRQ_I.global_interrupt_enable;
			// Pins float until the reset wait finishes
			CTL_O.pins_hiz <= int_reset || state_q == ST_RESET ||
				(state_q == ST_RST_WAIT && !wait_done);
			CTL_O.osc_enable <= !(state_q == ST_STOP && !wake_any) || int_reset;
			CTL_O.periph_stop <= state_q == ST_STOP;
			CTL_O.sub_periph_run <= state_q != ST_STOP ||
				(SUBCLK_RUNNING_I && SUBCLK_SELECTED_I);
			VECTOR_ADDR_O <= RESET_VECTOR_ADDR;
		end
	end

	assign STATE_O = state_q;

	// ****************************************
	// Assertions
	// ****************************************
	property p_reset_to_reset_state;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(CE_I && int_reset) |=> state_q == ST_RESET;
	endproperty
	a_reset_to_reset_state: assert property (p_reset_to_reset_state)
		else $error("internal reset did not return to reset state");

	property p_masked_stop_holds;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(CE_I && state_q == ST_STOP && !wake_any && !int_reset) |=> state_q == ST_STOP;
	endproperty
	a_masked_stop_holds: assert property (p_masked_stop_holds)
		else $error("STOP left without unmasked request");

	property p_halt_wake;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(CE_I && state_q == ST_HALT && (wake_any || IRQ_I.nmi) && !int_reset)
			|=> state_q == ST_RUN;
	endproperty
	a_halt_wake: assert property (p_halt_wake)
		else $error("HALT not released by request");

	property p_nmi_serviced;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(CE_I && state_q == ST_HALT && IRQ_I.nmi && !int_reset) |=> CTL_O.service_irq;
	endproperty
	a_nmi_serviced: assert property (p_nmi_serviced)
		else $error("non-maskable wake not serviced");

	property p_stop_entry;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(CE_I && state_q == ST_RUN && stop_req && !int_reset) |=> state_q == ST_STOP;
	endproperty
	a_stop_entry: assert property (p_stop_entry)
		else $error("STOP request did not enter STOP");

	property p_pins_hiz_reset;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(CE_I && int_reset) |=> CTL_O.pins_hiz;
	endproperty
	a_pins_hiz_reset: assert property (p_pins_hiz_reset)
		else $error("pins driven during reset");

	property p_periph_stopped;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(CE_I && state_q == ST_STOP) |=> CTL_O.periph_stop;
	endproperty
	a_periph_stopped: assert property (p_periph_stopped)
		else $error("peripherals running in STOP");

	property p_wsel_legal;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		##1 legal_sel(wsel_q);
	endproperty
	a_wsel_legal: assert property (p_wsel_legal)
		else $error("prohibited wait code stored");

	property p_reset_wait_fixed;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		state_q == ST_RST_WAIT |-> wait_term == WAIT_CNT_W'(WAIT_MID_CYC);
	endproperty
	a_reset_wait_fixed: assert property (p_reset_wait_fixed)
		else $error("reset wait not fixed length");
endmodule
`default_nettype wire

//--- core/srrc_wait_counter.sv
`timescale 1ns/1ps
`default_nettype none
module srrc_wait_counter (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic ce_i,
	// Control
	input wire logic start_i,
	input wire logic [srrc_pkg::WAIT_CNT_W-1:0] terminal_i,
	output logic done_o
);
	import srrc_pkg::*;

	logic [WAIT_CNT_W-1:0] cnt_q;
	logic running_q;

	// Counts main oscillator periods from start; done is a one-cycle pulse
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			cnt_q <= '0;
			running_q <= 1'b0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (start_i) begin
				cnt_q <= WAIT_CNT_W'(1);
				running_q <= 1'b1;
			end else if (running_q) begin
				if (cnt_q >= terminal_i) begin
					running_q <= 1'b0;
					done_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q + WAIT_CNT_W'(1);
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- verif/srrc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// CPU core, interrupt controller and reset pin
// ****************************************
module srrc_cpu_model (
	// Clock
	input wire logic clk_i,
	// Towards the block
	output srrc_pkg::srrc_irq_t irq_o,
	output logic halt_o,
	output logic stop_o,
	output logic rst_pin_n_o
);
	import srrc_pkg::*;

	initial begin
		irq_o = '0;
		halt_o = 1'b0;
		stop_o = 1'b0;
		rst_pin_n_o = 1'b1;
	end

	// One-cycle pulse, as the core gives when it executes the instruction
	task automatic exec(input logic stop);
		if (stop) begin
			stop_o <= 1'b1;
		end else begin
			halt_o <= 1'b1;
		end
		@(posedge clk_i);
		halt_o <= 1'b0;
		stop_o <= 1'b0;
	endtask

	task automatic set_irq(input srrc_irq_t v);
		irq_o <= v;
	endtask

	// Holds the pin low for cyc cycles; below the minimum low time the pin is not honoured
	task automatic pin_reset(input int unsigned cyc);
		rst_pin_n_o <= 1'b0;
		repeat (cyc) @(posedge clk_i);
		rst_pin_n_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

//--- verif/test_standby_release_reset_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_standby_release_reset_control;
	import srrc_pkg::*;
	// ****************************************
	// Stimulus and observation
	// ****************************************
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wdt = 1'b0;
	logic sup_ok = 1'b1;
	logic sub_run = 1'b0;
	logic sub_sel = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [2:0] hsize = 3'b000;
	logic ce = 1'b1;
	logic hresp;
	srrc_irq_t irq;
	logic halt_x, stop_x, pin_n, hready;
	srrc_ctl_t ctl;
	logic [15:0] vec;
	srrc_state_t st;
	logic [31:0] hrdata, rd;
	int failures = 0;
	int num_checks = 0;
	int n_svc = 0;
	int n_nxt = 0;
	int n_vec = 0;
	int n, s0, x0, v0;

	always #25 clk = ~clk;

	// Pulses stand one cycle, so exactly one edge sees each
	always @(posedge clk) begin
		n_svc += int'(ctl.service_irq === 1'b1);
		n_nxt += int'(ctl.next_instr === 1'b1);
		n_vec += int'(ctl.vector_fetch === 1'b1);
	end

	srrc_cpu_model u_srrc_cpu_model (.clk_i(clk), .irq_o(irq), .halt_o(halt_x),
		.stop_o(stop_x), .rst_pin_n_o(pin_n));

	srrc_top u_srrc_top (.CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .RESET_PIN_N_I(pin_n),
		.WDT_OVERFLOW_I(wdt), .SUPPLY_GOOD_I(sup_ok), .SUBCLK_RUNNING_I(sub_run),
		.SUBCLK_SELECTED_I(sub_sel), .IRQ_I(irq), .HALT_EXEC_I(halt_x), .STOP_EXEC_I(stop_x),
		.CTL_O(ctl), .VECTOR_ADDR_O(vec), .STATE_O(st), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
		.HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		chk(what, {31'h0, exp}, {31'h0, got});
	endtask

	// Latency is the designer's, so a few cycles of slack
	task automatic near(input string what, input int exp, input int got);
		chk1(what, 1'b1, got + 4 >= exp && got <= exp + 5);
	endtask

	task automatic final_report();
		$display("%0d checks, %0d mismatches", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'b010;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		chk1("hresp", 1'b0, hresp);
	endtask

	task automatic wait_st(input srrc_state_t s, input int lim);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (st !== s && n < lim);
	endtask

	task automatic halt_case(input srrc_irq_t v, input bit pend, input int svc);
		@(posedge clk);
		s0 = n_svc;
		x0 = n_nxt;
		if (pend) begin
			u_srrc_cpu_model.set_irq(v);
		end
		u_srrc_cpu_model.exec(1'b0);
		if (!pend) begin
			wait_st(ST_HALT, 4);
			repeat (10) @(posedge clk);
			chk("held", 32'(ST_HALT), 32'(st));
			u_srrc_cpu_model.set_irq(v);
		end
		wait_st(ST_RUN, 8);
		repeat (3) @(posedge clk);
		chk("service", 32'(svc), 32'(n_svc - s0));
		chk("next", 32'(1 - svc), 32'(n_nxt - x0));
		u_srrc_cpu_model.set_irq('0);
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		v0 = n_vec;
		wait_st(ST_RST_WAIT, 4);
		repeat (8) @(posedge clk);
		chk1("pins_hiz", 1'b1, ctl.pins_hiz);
		wait_st(ST_RUN, 33000);
		near("reset wait", WAIT_MID_CYC - 8, n);
		repeat (3) @(posedge clk);
		chk("vector fetch", 1, 32'(n_vec - v0));
		chk("vector", 32'(RESET_VECTOR_ADDR), 32'(vec));
		chk1("pins_hiz", 1'b0, ctl.pins_hiz);
		chk1("cpu", 1'b1, ctl.cpu_run);
		bus(1'b0, 32'(REG_WSEL), 0);
		chk("wait sel", 32'(WSEL_RESET), rd);
		bus(1'b1, 32'(REG_WSEL), 32'h0000_0003);
		bus(1'b0, 32'(REG_WSEL), 0);
		chk("wait sel", 32'(WSEL_RESET), rd);
		bus(1'b0, 32'h0000_0010, 0);
		chk("unmapped", 0, rd);
		$display("reset test done");

		u_srrc_cpu_model.set_irq(srrc_irq_t'({8'h01, 8'h01, 2'b01}));
		halt_case(srrc_irq_t'({8'h01, 8'h00, 2'b00}), 1'b0, 0);
		halt_case(srrc_irq_t'({8'h02, 8'h00, 2'b01}), 1'b1, 1);
		halt_case(srrc_irq_t'({8'h00, 8'hff, 2'b10}), 1'b0, 1);
		bus(1'b1, 32'(REG_CTRL), 32'h0000_0001);
		wait_st(ST_HALT, 4);
		chk("sw halt", 32'(ST_HALT), 32'(st));
		u_srrc_cpu_model.set_irq(srrc_irq_t'({8'h00, 8'h00, 2'b10}));
		wait_st(ST_RUN, 4);
		chk("sw halt wake", 32'(ST_RUN), 32'(st));
		u_srrc_cpu_model.set_irq('0);
		$display("halt test done");

		bus(1'b1, 32'(REG_WSEL), 32'(WSEL_SHORT));
		u_srrc_cpu_model.set_irq(srrc_irq_t'({8'h01, 8'h01, 2'b01}));
		u_srrc_cpu_model.exec(1'b1);
		wait_st(ST_STOP, 4);
		repeat (20) @(posedge clk);
		chk("stopped", 32'(ST_STOP), 32'(st));
		chk1("osc", 1'b0, ctl.osc_enable);
		chk1("cpu", 1'b0, ctl.cpu_run);
		chk1("periph", 1'b1, ctl.periph_stop);
		chk1("sub periph", 1'b0, ctl.sub_periph_run);
		sub_run <= 1'b1;
		repeat (3) @(posedge clk);
		chk1("sub periph", 1'b0, ctl.sub_periph_run);
		sub_sel <= 1'b1;
		repeat (3) @(posedge clk);
		chk1("sub periph", 1'b1, ctl.sub_periph_run);
		s0 = n_svc;
		ce <= 1'b0;
		u_srrc_cpu_model.set_irq(srrc_irq_t'({8'h01, 8'h00, 2'b01}));
		repeat (5) @(posedge clk);
		chk("frozen", 32'(ST_STOP), 32'(st));
		ce <= 1'b1;
		wait_st(ST_STOP_WAIT, 4);
		wait_st(ST_RUN, 4200);
		near("stop wait", WAIT_SHORT_CYC, n);
		repeat (3) @(posedge clk);
		chk("service", 1, 32'(n_svc - s0));
		bus(1'b0, 32'(REG_STATUS), 0);
		chk("status", 32'h0000_0012, rd);
		u_srrc_cpu_model.set_irq('0);
		sub_run <= 1'b0;
		sub_sel <= 1'b0;
		$display("stop test done");

		u_srrc_cpu_model.exec(1'b1);
		wait_st(ST_STOP, 4);
		v0 = n_vec;
		fork
			u_srrc_cpu_model.pin_reset(EXT_RESET_MIN_CYC + 2);
			begin
				repeat (EXT_RESET_MIN_CYC + 2) @(posedge clk);
				chk1("pins_hiz", 1'b1, ctl.pins_hiz);
			end
		join
		wait_st(ST_RUN, 33000);
		near("reset wait", WAIT_MID_CYC, n);
		repeat (3) @(posedge clk);
		chk("vector fetch", 1, 32'(n_vec - v0));
		bus(1'b0, 32'(REG_WSEL), 0);
		chk("wait sel", 32'(WSEL_RESET), rd);
		$display("stop reset test done");

		u_srrc_cpu_model.pin_reset(EXT_RESET_MIN_CYC - 1);
		repeat (3) @(posedge clk);
		chk("short pin", 32'(ST_RUN), 32'(st));
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		wait_st(ST_RST_WAIT, 6);
		chk("wdt reset", 32'(ST_RST_WAIT), 32'(st));
		repeat (3) @(posedge clk);
		chk1("pins_hiz", 1'b1, ctl.pins_hiz);
		sup_ok <= 1'b0;
		repeat (10) @(posedge clk);
		chk("supply reset", 32'(ST_RESET), 32'(st));
		sup_ok <= 1'b1;
		wait_st(ST_RST_WAIT, 6);
		chk("supply release", 32'(ST_RST_WAIT), 32'(st));
		$display("reset source test done");
		final_report();
	end

	// Tests need about 71000 cycles
	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		final_report();
	end
endmodule
`default_nettype wire
